// ==== rtl/result_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             arst_n_in,
  input  wire logic             ce_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      rptr_r;
  logic [AW:0]      rptr_nxt;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;
  // ==========================================================
  // flags
  assign full         = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
  assign empty        = (wptr_r == rptr_r);
  assign wr_ready_out = !full;
  assign do_wr        = ce_in && wr_valid_in && !full;
  assign do_rd        = ce_in && rd_ready_in && rd_valid_out;
  assign rptr_nxt     = do_rd ? rptr_r + 1'b1 : rptr_r;
  // storage write
  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem_r[wptr_r[AW-1:0]] <= wr_data_in;
    end
  end
  // pointers and registered read data
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wptr_r       <= '0;
      rptr_r       <= '0;
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end else if (ce_in) begin
      if (do_wr) begin
        wptr_r <= wptr_r + 1'b1;
      end
      rptr_r <= rptr_nxt;
      if (!rd_valid_out || do_rd) begin
        rd_valid_out <= (rptr_nxt != wptr_r);
        rd_data_out  <= mem_r[rptr_nxt[AW-1:0]];
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/sar_seq_pkg.sv ====
package sar_seq_pkg;
  // ==========================================================
  // converter geometry
  localparam int          RESULT_BITS   = 6;
  localparam logic [5:0]  RESULT_RST    = 6'h00;
  localparam logic [5:0]  RESULT_FULL   = 6'h3F;
  localparam logic [2:0]  TOP_BIT_IDX   = 3'h5;
  localparam logic [3:0]  CONV_CYCLES   = 4'h8;
  // ==========================================================
  // timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          START_HIGH_NS = 500;
  localparam int          START_HIGH_CYC =
    (START_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // result fifo
  localparam int          FIFO_WIDTH    = 6;
  localparam int          FIFO_DEPTH    = 16;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARM   = 2'b01,
    ST_TRIAL = 2'b10,
    ST_DONE  = 2'b11
  } seq_state_t;
endpackage

// ==== rtl/serial_sar_adc_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
module serial_sar_adc_sequencer (
  input  wire logic                            clk_sys_in,
  input  wire logic                            arst_n_in,
  input  wire logic                            ce_in,
  input  wire logic                            start_n_in,
  input  wire logic                            conv_clk_in,
  input  wire logic                            ref_above_in,
  output logic                                 dout_out,
  output logic                                 dout_oe_n_out,
  output logic [sar_seq_pkg::RESULT_BITS-1:0] trial_code_out,
  output logic                                 busy_out,
  output logic                                 start_ok_out,
  output logic                                 res_valid_out,
  input  wire logic                            res_ready_in,
  output logic [sar_seq_pkg::RESULT_BITS-1:0] res_data_out,
  output logic                                 res_overflow_out
);
  import sar_seq_pkg::*;

  // ==========================================================
  // registers
  seq_state_t             state_r;
  seq_state_t             state_nxt;
  logic [RESULT_BITS-1:0] approximation_register_r;
  logic [RESULT_BITS-1:0] approx_nxt;
  logic [2:0]             bit_idx_r;
  logic [2:0]             bit_idx_nxt;
  logic                   conv_clk_d_r;
  logic                   start_n_d_r;
  logic                   dout_r;
  logic                   dout_nxt;
  logic [9:0]             high_cnt_r;
  logic                   push_r;
  logic                   ovf_r;
  logic                   fifo_wr_ready;

  // ==========================================================
  // edge detection on synchronous inputs
  logic clk_fall;
  logic start_fall;
  logic start_hi;
  assign clk_fall   = conv_clk_d_r && !conv_clk_in;
  assign start_fall = start_n_d_r && !start_n_in;
  assign start_hi   = start_n_in;

  function automatic logic [RESULT_BITS-1:0] bit_mask(input logic [2:0] idx);
    bit_mask = RESULT_BITS'(1) << idx;
  endfunction

  // ==========================================================
  // next-state decode
  logic [RESULT_BITS-1:0] cur_mask;
  logic [RESULT_BITS-1:0] decided;
  assign cur_mask = bit_mask(bit_idx_r);
  // decision: clear bit if reference larger, else keep at 1
  assign decided  = ref_above_in ? (approximation_register_r & ~cur_mask)
                                 : approximation_register_r;

  // step to the next lower trial bit
  logic                   last_bit;
  logic [2:0]             lower_idx;
  logic [RESULT_BITS-1:0] next_trial;
  assign last_bit   = (bit_idx_r == 3'h0);
  assign lower_idx  = bit_idx_r - 3'h1;
  assign next_trial = decided | bit_mask(lower_idx);

  always_comb begin
    state_nxt   = state_r;
    approx_nxt  = approximation_register_r;
    bit_idx_nxt = bit_idx_r;
    dout_nxt    = dout_r;
    if (start_hi) begin
      state_nxt   = ST_IDLE;
      approx_nxt  = RESULT_RST;
      bit_idx_nxt = TOP_BIT_IDX;
    end else if (start_fall) begin
      state_nxt   = ST_ARM;
      approx_nxt  = RESULT_RST;
      bit_idx_nxt = TOP_BIT_IDX;
    end else if (clk_fall) begin
      case (state_r)
        ST_ARM: begin
          // first falling edge: apply top trial bit
          state_nxt  = ST_TRIAL;
          approx_nxt = bit_mask(TOP_BIT_IDX);
        end
        ST_TRIAL: begin
          // decide current bit, present it, then try the next lower one
          dout_nxt = decided[bit_idx_r];
          if (last_bit) begin
            approx_nxt = decided;
            state_nxt  = ST_DONE;
          end else begin
            approx_nxt  = next_trial;
            bit_idx_nxt = lower_idx;
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  // ==========================================================
  // input history for edge detection, idle levels after reset
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_clk_d_r <= 1'b0; // conversion clock idles low
      start_n_d_r  <= 1'b1; // start idles high, no false start
    end else if (ce_in) begin
      conv_clk_d_r <= conv_clk_in;
      start_n_d_r  <= start_n_in;
    end
  end

  // sequencer state
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_IDLE;
    end else if (ce_in) begin
      state_r <= state_nxt;
    end
  end

  // approximation register, shown as the trial code
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      approximation_register_r <= RESULT_RST;
    end else if (ce_in) begin
      approximation_register_r <= approx_nxt;
    end
  end

  // index of the bit under trial
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_idx_r <= TOP_BIT_IDX;
    end else if (ce_in) begin
      bit_idx_r <= bit_idx_nxt;
    end
  end

  // serial data, held until the next decision
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dout_r <= 1'b0;
    end else if (ce_in) begin
      dout_r <= dout_nxt;
    end
  end

  // ==========================================================
  // start-high time monitor and result push
  logic in_arm;
  logic in_trial;
  logic conv_ending;
  assign in_arm      = (state_r == ST_ARM);
  assign in_trial    = (state_r == ST_TRIAL);
  assign conv_ending = in_trial && (state_nxt == ST_DONE);

  // counts start-high time, saturating at the recognition threshold
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      high_cnt_r <= '0;
    end else if (ce_in) begin
      if (!start_hi) begin
        high_cnt_r <= '0;
      end else if (high_cnt_r != 10'(START_HIGH_CYC)) begin
        high_cnt_r <= high_cnt_r + 10'h001;
      end
    end
  end

  // one-cycle push once the last decision has settled in the register
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      push_r <= 1'b0;
    end else if (ce_in) begin
      push_r <= conv_ending;
    end
  end

  // sticky overflow: a finished result met a full queue and was lost
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ovf_r <= 1'b0;
    end else if (ce_in && push_r && !fifo_wr_ready) begin
      ovf_r <= 1'b1;
    end
  end

  // ==========================================================
  // outputs
  assign dout_out         = dout_r;
  assign dout_oe_n_out    = start_hi;
  assign trial_code_out   = approximation_register_r;
  assign busy_out         = in_arm || in_trial;
  assign start_ok_out     = (high_cnt_r == 10'(START_HIGH_CYC));
  assign res_overflow_out = ovf_r;

  // completed results queue for the user side
  result_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .arst_n_in    (arst_n_in),
    .ce_in        (ce_in),
    .wr_valid_in  (push_r),
    .wr_ready_out (fifo_wr_ready),
    .wr_data_in   (approximation_register_r),
    .rd_valid_out (res_valid_out),
    .rd_ready_in  (res_ready_in),
    .rd_data_out  (res_data_out)
  );
endmodule
`default_nettype wire

// ==== tb/sar_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module sar_host_model
  import sar_seq_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       dout_out,
  input  wire logic [5:0] trial_code_out,
  output logic            start_n_in,
  output logic            conv_clk_in,
  output logic            ref_above_in
);
  logic [6:0] vin = 7'h00;
  // comparator: reference above input
  assign ref_above_in = {1'b0, trial_code_out} > vin;
  initial begin
    start_n_in = 1'b1;
    conv_clk_in = 1'b0;
  end
  // ==========================================================
  // one conversion frame, clock stands low outside it
  task automatic convert(input logic [6:0] v, input int pulses, output logic [5:0] b,
                         output logic [5:0] tc);
    vin <= v;
    start_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    for (int i = 1; i <= pulses; i++) begin
      conv_clk_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      conv_clk_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      if (i >= 2 && i <= 7) b[7-i] = dout_out;
    end
    tc = trial_code_out;
    start_n_in <= 1'b1;
    repeat (START_HIGH_CYC + 2) @(posedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

// ==== tb/sar_seq_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module sar_seq_asserts (
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  input  wire logic       ce_in,
  input  wire logic       start_n_in,
  input  wire logic       conv_clk_in,
  input  wire logic       ref_above_in,
  input  wire logic       dout_out,
  input  wire logic       dout_oe_n_out,
  input  wire logic [5:0] trial_code_out,
  input  wire logic       busy_out
);
  logic       cc_q;
  logic       sn_q;
  logic [2:0] cnt_r;
  wire        fall = cc_q & ~conv_clk_in;
  // ==========================================================
  // helper: edge history and count of clock falls since start
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cc_q <= 1'b0;
      sn_q <= 1'b1;
      cnt_r <= 3'h0;
    end else if (ce_in) begin
      cc_q <= conv_clk_in;
      sn_q <= start_n_in;
      if (start_n_in || sn_q) cnt_r <= 3'h0;
      else if (fall && cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  // the design is frozen while the enable is low, so checks pause too
  default disable iff (!arst_n_in || !ce_in);
  sequence s_arm;
    !sn_q && !start_n_in && cnt_r == 3'h0 && fall;
  endsequence
  sequence s_decide;
    !start_n_in && fall && cnt_r inside {[3'h1:3'h6]};
  endsequence
  // ==========================================================
  // properties
  property p_float; dout_oe_n_out == start_n_in; endproperty
  property p_idle; start_n_in [*2] |-> trial_code_out == 6'h00 && !busy_out; endproperty
  property p_arm; s_arm |=> trial_code_out == 6'h20 && busy_out; endproperty
  property p_first;
    s_decide ##0 cnt_r == 3'h1 |=> !dout_oe_n_out && trial_code_out[5] == dout_out;
  endproperty
  property p_decide; s_decide |=> start_n_in || dout_out == !$past(ref_above_in); endproperty
  property p_next;
    s_decide ##0 cnt_r != 3'h6 |=> trial_code_out[3'h5 - $past(cnt_r)];
  endproperty
  property p_abort; busy_out && start_n_in |=> !busy_out ##1 trial_code_out == 6'h00; endproperty
  property p_done; s_decide ##0 cnt_r == 3'h6 |=> !busy_out; endproperty
  a_float: assert property (p_float) else $error("output enable wrong");
  a_idle: assert property (p_idle) else $error("not idle");
  a_arm: assert property (p_arm) else $error("top trial missing");
  a_first: assert property (p_first) else $error("top bit invalid");
  a_decide: assert property (p_decide) else $error("bad decision");
  a_next: assert property (p_next) else $error("next bit not tried");
  a_abort: assert property (p_abort) else $error("abort failed");
  a_done: assert property (p_done) else $error("not done in time");
endmodule
bind serial_sar_adc_sequencer sar_seq_asserts chk_i (
  .clk_sys_in     (clk_sys_in),
  .arst_n_in      (arst_n_in),
  .ce_in          (ce_in),
  .start_n_in     (start_n_in),
  .conv_clk_in    (conv_clk_in),
  .ref_above_in   (ref_above_in),
  .dout_out       (dout_out),
  .dout_oe_n_out  (dout_oe_n_out),
  .trial_code_out (trial_code_out),
  .busy_out       (busy_out)
);
`default_nettype wire

// ==== tb/serial_sar_adc_sequencer_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module serial_sar_adc_sequencer_bench;
  import sar_seq_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        res_ready_in = 1'b0;
  logic        ce_in = 1'b1;
  wire logic   start_n_in, conv_clk_in, ref_above_in, dout_out, dout_oe_n_out;
  wire logic   busy_out, start_ok_out, res_valid_out, res_overflow_out;
  wire logic [5:0] trial_code_out, res_data_out;
  int          n_errors = 0;
  int          checked = 0;
  logic [5:0]  bits, tc;
  logic [12:0] rows [8] = '{13'h0000, 13'h0041, 13'h0820, 13'h0AAA, 13'h0555,
                            13'h0FBE, 13'h0FFF, 13'h11BF};
  always #5 clk_sys_in = ~clk_sys_in;
  serial_sar_adc_sequencer dut (.clk_sys_in, .arst_n_in, .ce_in, .start_n_in,
    .conv_clk_in, .ref_above_in, .dout_out, .dout_oe_n_out, .trial_code_out, .busy_out,
    .start_ok_out, .res_valid_out, .res_ready_in, .res_data_out, .res_overflow_out);
  sar_host_model host (.clk_sys_in, .dout_out, .trial_code_out, .start_n_in, .conv_clk_in,
    .ref_above_in);
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic pop;
    res_ready_in <= 1'b1;
    @(posedge clk_sys_in);
    res_ready_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    report_and_stop;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    chk("reset code", {1'b0, RESULT_RST}, {1'b0, trial_code_out});
    chk("reset float", 7'h01, {6'h00, dout_oe_n_out});
    chk("reset busy", 7'h00, {6'h00, busy_out});
    chk("reset start ok", 7'h00, {6'h00, start_ok_out});
    for (int i = 0; i < 8; i++) begin
      host.convert(rows[i][12:6], 8, bits, tc);
      chk("serial", {1'b0, rows[i][5:0]}, {1'b0, bits});
      chk("code", {1'b0, rows[i][5:0]}, {1'b0, tc});
      chk("idle code", 7'h00, {1'b0, trial_code_out});
      chk("idle busy", 7'h00, {6'h00, busy_out});
      chk("start ok", 7'h01, {6'h00, start_ok_out});
      chk("fifo", {1'b1, rows[i][5:0]}, {res_valid_out, res_data_out});
      pop;
    end
    $display("table done");
    host.convert(7'h2A, 4, bits, tc);
    chk("abort float", 7'h01, {6'h00, dout_oe_n_out});
    host.convert(7'h15, 8, bits, tc);
    chk("restart serial", 7'h15, {1'b0, bits});
    chk("restart fifo", 7'h55, {res_valid_out, res_data_out});
    pop;
    $display("abort done");
    ce_in <= 1'b0;
    host.convert(7'h2A, 8, bits, tc);
    chk("frozen code", 7'h00, {1'b0, tc});
    chk("frozen fifo", 7'h00, {res_valid_out, 6'h00});
    ce_in <= 1'b1;
    host.convert(7'h2A, 8, bits, tc);
    chk("resumed code", 7'h2A, {1'b0, tc});
    chk("resumed fifo", 7'h6A, {res_valid_out, res_data_out});
    pop;
    $display("enable done");
    for (int i = 0; i < 17; i++) host.convert(i[6:0], 8, bits, tc);
    chk("overflow", 7'h01, {6'h00, res_overflow_out});
    for (int i = 0; i < 16; i++) begin
      chk("drain", {1'b1, i[5:0]}, {res_valid_out, res_data_out});
      pop;
    end
    chk("empty", 7'h00, {res_valid_out, 6'h00});
    $display("fifo done");
    report_and_stop;
  end
endmodule
`default_nettype wire
